// file: rtl/tpfu_top.sv
// Operation
// - Prescale select 00/01/10/11 divides the count clock by 1/4/8/16.
// - In normal mode prescale select takes one write, within 64 cycles of reset.
// - Enable bits 7..4 pair with flag bits 7..4; set and enabled raises interrupt.
// - Flags: bit7 counter wrap, bit6 periodic tick, bit5 acc wrap, bit4 acc edge.
// - Writing one to a flag bit clears it; writing zero leaves it alone.
// - Counter wrap flag sets on the step from all ones to all zeros.
// - Periodic tick flag sets repeatedly at the interval the rate select picks.
module tpfu_top #(
    parameter int unsigned RTI_BASE = 8192
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic normal_mode,
    input wire logic acc_wrap_evt,
    input wire logic acc_edge_evt,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    output logic [15:0] free_running_count,
    output logic irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] presc;
        logic [15:0] count;
        logic [16:0] rti;
        logic [3:0] flags;
        logic [3:0] mask;
        logic [1:0] psel;
        logic [1:0] rsel;
        logic locked;
        logic [6:0] boot_cnt;
        logic [7:0] rdata;
        logic irq;
    } tpfu_state_t;

    tpfu_state_t s_q;
    tpfu_state_t s_d;
    logic tick;
    logic wrap_hit;
    logic rti_hit;
    logic psel_ok;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Prescaler output pulse for the chosen ratio
    function automatic logic tpfu_div_tick(input logic [1:0] sel, input logic [3:0] cnt);
        logic t;
        t = 1'b1;
        case (sel)
            tpfu_pkg::TPFU_DIV1: t = 1'b1;
            tpfu_pkg::TPFU_DIV4: t = (cnt[1:0] == 2'h3);
            tpfu_pkg::TPFU_DIV8: t = (cnt[2:0] == 3'h7);
            tpfu_pkg::TPFU_DIV16: t = (cnt == 4'hF);
            default: t = 1'b1;
        endcase
        return t;
    endfunction

    // Last count of the periodic interval
    function automatic logic [16:0] tpfu_rti_last(input logic [1:0] sel);
        return 17'((RTI_BASE << sel) - 1);
    endfunction

    // ------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------
    // Count pulse, wrap and periodic events
    assign tick = tpfu_div_tick(s_q.psel, s_q.presc);
    assign wrap_hit = tick && (s_q.count == 16'hFFFF);
    // A count already past the end after a rate change ends the interval at once
    assign rti_hit = (s_q.rti >= tpfu_rti_last(s_q.rsel));
    // Select write allowed once, early, in normal mode
    assign psel_ok = !normal_mode ||
        (!s_q.locked && (s_q.boot_cnt < tpfu_pkg::TPFU_SEL_WINDOW_CYC));

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.presc = s_q.presc + 4'h1;
        if (tick)
        begin
            s_d.count = s_q.count + 16'h0001;
        end
        if (rti_hit)
        begin
            s_d.rti = 17'h00000;
        end
        else
        begin
            s_d.rti = s_q.rti + 17'h00001;
        end
        if (s_q.boot_cnt != tpfu_pkg::TPFU_SEL_WINDOW_CYC)
        begin
            s_d.boot_cnt = s_q.boot_cnt + 7'h01;
        end
        // Register writes
        if (wr_en)
        begin
            case (addr)
                tpfu_pkg::TPFU_ADDR_FLAGS:
                begin
                    s_d.flags = s_q.flags & ~wdata[7:4];
                end
                tpfu_pkg::TPFU_ADDR_ENABLES:
                begin
                    s_d.mask = wdata[7:4];
                    if (psel_ok)
                    begin
                        s_d.psel = wdata[1:0];
                        s_d.locked = s_q.locked | normal_mode;
                    end
                end
                tpfu_pkg::TPFU_ADDR_ACC_CTL:
                begin
                    s_d.rsel = wdata[1:0];
                end
                default:
                begin
                    s_d.rsel = s_d.rsel;
                end
            endcase
        end
        // Events set after the clear so a set wins
        s_d.flags = s_d.flags | {wrap_hit, rti_hit, acc_wrap_evt, acc_edge_evt};
        // Read data for the next cycle only
        s_d.rdata = 8'h00;
        if (rd_en)
        begin
            case (addr)
                tpfu_pkg::TPFU_ADDR_FLAGS: s_d.rdata = {s_q.flags, 4'h0};
                tpfu_pkg::TPFU_ADDR_ENABLES: s_d.rdata = {s_q.mask, 2'h0, s_q.psel};
                tpfu_pkg::TPFU_ADDR_ACC_CTL: s_d.rdata = {6'h00, s_q.rsel};
                tpfu_pkg::TPFU_ADDR_CNT_HI: s_d.rdata = s_q.count[15:8];
                tpfu_pkg::TPFU_ADDR_CNT_LO: s_d.rdata = s_q.count[7:0];
                default: s_d.rdata = 8'h00;
            endcase
        end
        // Level interrupt from enabled flags
        s_d.irq = |(s_d.flags & s_d.mask);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Synchronous reset clears everything
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.flags <= tpfu_pkg::TPFU_FLAGS_RST;
            s_q.mask <= tpfu_pkg::TPFU_MASK_RST;
            s_q.psel <= tpfu_pkg::TPFU_SEL_RST;
            s_q.count <= tpfu_pkg::TPFU_COUNT_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign rdata = s_q.rdata;
    assign free_running_count = s_q.count;
    assign irq = s_q.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    chk_div_one_step: assert property (
        (s_q.psel == tpfu_pkg::TPFU_DIV1) |=> (s_q.count == 16'($past(s_q.count) + 16'h0001)))
        else $error("count did not step every cycle at divide by one");

    chk_div_four_rate: assert property (
        (s_q.psel == tpfu_pkg::TPFU_DIV4) && !(wr_en && addr == tpfu_pkg::TPFU_ADDR_ENABLES)
        |=> ((s_q.count != $past(s_q.count)) == ($past(s_q.presc[1:0]) == 2'h3)))
        else $error("divide by four step out of phase");

    chk_sel_locked: assert property (
        normal_mode && (s_q.locked || s_q.boot_cnt == tpfu_pkg::TPFU_SEL_WINDOW_CYC)
        |=> $stable(s_q.psel))
        else $error("prescale select changed after lock");

    chk_irq_pairing: assert property (
        ##1 (irq == |(s_q.flags & s_q.mask)))
        else $error("interrupt does not match enabled flags");

    chk_flag_readback: assert property (
        rd_en && (addr == tpfu_pkg::TPFU_ADDR_FLAGS)
        |=> (rdata == {$past(s_q.flags), 4'h0}))
        else $error("flag read wrong layout");

    chk_w1c_clear: assert property (
        wr_en && (addr == tpfu_pkg::TPFU_ADDR_FLAGS) && wdata[7] && !wrap_hit
        |=> !s_q.flags[3])
        else $error("write one did not clear wrap flag");

    chk_wrap_flag: assert property (
        (s_q.count == 16'hFFFF) ##1 (s_q.count == 16'h0000) |-> s_q.flags[3])
        else $error("wrap flag missing after rollover");

    chk_tick_flag: assert property (
        (s_q.rti == tpfu_rti_last(s_q.rsel)) |=> s_q.flags[2] && (s_q.rti == 17'h00000))
        else $error("periodic tick flag missing");

    chk_reset_clear: assert property (
        $past(rst) |-> (s_q.flags == 4'h0) && (s_q.count == 16'h0000) && !irq)
        else $error("state not cleared by reset");

    // Remaining prescaler ratios
    chk_div_eight_rate: assert property (
        (s_q.psel == tpfu_pkg::TPFU_DIV8) && !(wr_en && addr == tpfu_pkg::TPFU_ADDR_ENABLES)
        |=> ((s_q.count != $past(s_q.count)) == ($past(s_q.presc[2:0]) == 3'h7)))
        else $error("divide by eight step out of phase");

    chk_div_sixteen_rate: assert property (
        (s_q.psel == tpfu_pkg::TPFU_DIV16) && !(wr_en && addr == tpfu_pkg::TPFU_ADDR_ENABLES)
        |=> ((s_q.count != $past(s_q.count)) == ($past(s_q.presc) == 4'hF)))
        else $error("divide by sixteen step out of phase");

    // Select writes that must land
    chk_sel_window_take: assert property (
        normal_mode && wr_en && (addr == tpfu_pkg::TPFU_ADDR_ENABLES) && !s_q.locked
        && (s_q.boot_cnt < tpfu_pkg::TPFU_SEL_WINDOW_CYC)
        |=> (s_q.psel == $past(wdata[1:0])) && s_q.locked)
        else $error("select write inside window not taken");

    chk_sel_special_take: assert property (
        !normal_mode && wr_en && (addr == tpfu_pkg::TPFU_ADDR_ENABLES)
        |=> (s_q.psel == $past(wdata[1:0])))
        else $error("select write in special mode not taken");

    // Enable register
    chk_mask_write: assert property (
        wr_en && (addr == tpfu_pkg::TPFU_ADDR_ENABLES) |=> (s_q.mask == $past(wdata[7:4])))
        else $error("enable bits not written");

    chk_enables_readback: assert property (
        rd_en && (addr == tpfu_pkg::TPFU_ADDR_ENABLES)
        |=> (rdata == {$past(s_q.mask), 2'h0, $past(s_q.psel)}))
        else $error("enable read wrong layout");

    // Event inputs land in their own flag bits
    chk_acc_wrap_set: assert property (
        acc_wrap_evt |=> s_q.flags[1])
        else $error("accumulator wrap flag not set");

    chk_acc_edge_set: assert property (
        acc_edge_evt |=> s_q.flags[0])
        else $error("accumulator edge flag not set");

    // Flags only fall through a write of one
    chk_flag_sticky: assert property (
        !(wr_en && (addr == tpfu_pkg::TPFU_ADDR_FLAGS))
        |=> (($past(s_q.flags) & ~s_q.flags) == 4'h0))
        else $error("flag dropped without a clear");

    chk_w1c_keep: assert property (
        wr_en && (addr == tpfu_pkg::TPFU_ADDR_FLAGS)
        |=> (($past(s_q.flags) & ~$past(wdata[7:4]) & ~s_q.flags) == 4'h0))
        else $error("write of zero cleared a flag");

    // Flags rise only at their own event
    chk_wrap_only: assert property (
        (s_q.count != 16'hFFFF) |=> !$rose(s_q.flags[3]))
        else $error("wrap flag rose without rollover");

    chk_tick_only: assert property (
        (s_q.rti < tpfu_rti_last(s_q.rsel)) |=> !$rose(s_q.flags[2]))
        else $error("periodic tick flag rose early");

    // Counter step and readback
    chk_count_step: assert property (
        tick |=> (s_q.count == 16'($past(s_q.count) + 16'h0001)))
        else $error("counter missed a prescaler pulse");

    chk_count_readback: assert property (
        rd_en && (addr == tpfu_pkg::TPFU_ADDR_CNT_HI) |=> (rdata == $past(s_q.count[15:8])))
        else $error("counter high byte read wrong");

    cov_wrap: cover property (wrap_hit ##1 irq);
    cov_late_write: cover property (wr_en && addr == tpfu_pkg::TPFU_ADDR_ENABLES && !psel_ok);
    cov_set_beats_clear: cover property (wr_en && addr == tpfu_pkg::TPFU_ADDR_FLAGS
        && wdata[4] && acc_edge_evt);
    cov_tick_irq: cover property (rti_hit ##1 irq);
    cov_div16_step: cover property (tick && (s_q.psel == tpfu_pkg::TPFU_DIV16));

endmodule

// file: rtl/tpfu_pkg.sv
package tpfu_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] TPFU_ADDR_CNT_HI = 16'h000E;
    localparam logic [15:0] TPFU_ADDR_CNT_LO = 16'h000F;
    localparam logic [15:0] TPFU_ADDR_ENABLES = 16'h0024;
    localparam logic [15:0] TPFU_ADDR_FLAGS = 16'h0025;
    localparam logic [15:0] TPFU_ADDR_ACC_CTL = 16'h0026;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TPFU_BIT_COUNTER_WRAP = 7;
    localparam int TPFU_BIT_PERIODIC_TICK = 6;
    localparam int TPFU_BIT_ACC_WRAP = 5;
    localparam int TPFU_BIT_ACC_EDGE = 4;
    localparam int TPFU_SEL_LSB = 0;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [3:0] TPFU_FLAGS_RST = 4'h0;
    localparam logic [3:0] TPFU_MASK_RST = 4'h0;
    localparam logic [1:0] TPFU_SEL_RST = 2'h0;
    localparam logic [15:0] TPFU_COUNT_RST = 16'h0000;

    // ------------------------------------------------------------
    // Prescale select codes
    // ------------------------------------------------------------
    localparam logic [1:0] TPFU_DIV1 = 2'h0;
    localparam logic [1:0] TPFU_DIV4 = 2'h1;
    localparam logic [1:0] TPFU_DIV8 = 2'h2;
    localparam logic [1:0] TPFU_DIV16 = 2'h3;

    // ------------------------------------------------------------
    // Cycle counts and clock period
    // ------------------------------------------------------------
    localparam logic [6:0] TPFU_SEL_WINDOW_CYC = 7'h40;
    localparam int TPFU_CLK_PERIOD_NS = 20;

endpackage

// file: verif/test_timer_prescale_and_flag_unit.sv
module test_timer_prescale_and_flag_unit;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic normal_mode = 1'b1;
    logic acc_wrap_evt = 1'b0;
    logic acc_edge_evt = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rdata;
    logic [15:0] free_running_count;
    logic irq;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [15:0] c0;

    tpfu_top #(.RTI_BASE(16)) i_dut (.core_clk(core_clk), .rst(rst), .normal_mode(normal_mode),
        .acc_wrap_evt(acc_wrap_evt), .acc_edge_evt(acc_edge_evt), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .free_running_count(free_running_count),
        .irq(irq));

    // ------------------------------------------------------------
    // Clock and cycle ceiling
    // ------------------------------------------------------------
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            err_count++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic cmp(string name, logic [15:0] e, logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge core_clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(logic [15:0] a, logic [7:0] e, logic [7:0] m);
        @(posedge core_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 cmp("rdata", {8'h00, e}, {8'h00, rdata & m});
    endtask
    task automatic div_chk(logic [15:0] e);
        @(posedge core_clk);
        #1 c0 = free_running_count;
        repeat (64) @(posedge core_clk);
        #1 cmp("count_step", e, free_running_count - c0);
    endtask
    // Reads the flags every other cycle until a masked bit shows
    task automatic poll_flag(logic [7:0] m);
        logic [7:0] d;
        d = 8'h00;
        for (int n = 0; n < 300 && (d & m) == 8'h00; n++)
        begin
            @(posedge core_clk);
            rd_en <= 1'b1;
            addr <= tpfu_pkg::TPFU_ADDR_FLAGS;
            @(posedge core_clk);
            rd_en <= 1'b0;
            #1 d = rdata;
        end
        cmp("poll_flag", {8'h00, m}, {8'h00, d & m});
    endtask
    task automatic do_reset();
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        // Reset held for two edges at start
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        #1 cmp("count_rst", 16'h0000, free_running_count);
        rd(tpfu_pkg::TPFU_ADDR_FLAGS, 8'h00, 8'hBF);
        rd(tpfu_pkg::TPFU_ADDR_ENABLES, 8'h00, 8'hFF);
        rd(16'h0030, 8'h00, 8'hFF);
        // Write once in window, second write locked out
        wr(tpfu_pkg::TPFU_ADDR_ENABLES, 8'h01);
        div_chk(16'h0010);
        wr(tpfu_pkg::TPFU_ADDR_ENABLES, 8'h03);
        div_chk(16'h0010);
        // Late write after the window is ignored
        do_reset();
        repeat (70) @(posedge core_clk);
        wr(tpfu_pkg::TPFU_ADDR_ENABLES, 8'h02);
        div_chk(16'h0040);
        // Special mode walks every divider
        @(posedge core_clk);
        normal_mode <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            wr(tpfu_pkg::TPFU_ADDR_ENABLES, 8'(i));
            div_chk((i == 0) ? 16'h0040 : 16'(32 >> i));
        end
        // Event flags, masking and clearing
        do_reset();
        @(posedge core_clk);
        acc_wrap_evt <= 1'b1;
        @(posedge core_clk);
        acc_wrap_evt <= 1'b0;
        acc_edge_evt <= 1'b1;
        @(posedge core_clk);
        acc_edge_evt <= 1'b0;
        rd(tpfu_pkg::TPFU_ADDR_FLAGS, 8'h30, 8'hBF);
        cmp("irq", 16'h0000, {15'h0000, irq});
        wr(tpfu_pkg::TPFU_ADDR_ENABLES, 8'h20);
        repeat (2) @(posedge core_clk);
        #1 cmp("irq", 16'h0001, {15'h0000, irq});
        wr(tpfu_pkg::TPFU_ADDR_FLAGS, 8'h20);
        repeat (2) @(posedge core_clk);
        #1 cmp("irq", 16'h0000, {15'h0000, irq});
        rd(tpfu_pkg::TPFU_ADDR_FLAGS, 8'h10, 8'hBF);
        // Clear of the edge flag meets a fresh edge event: set wins
        @(posedge core_clk);
        wr_en <= 1'b1;
        addr <= tpfu_pkg::TPFU_ADDR_FLAGS;
        wdata <= 8'h10;
        acc_edge_evt <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
        acc_edge_evt <= 1'b0;
        rd(tpfu_pkg::TPFU_ADDR_FLAGS, 8'h10, 8'hBF);
        // Periodic tick at the shortest and longest rate
        wr(tpfu_pkg::TPFU_ADDR_FLAGS, 8'h40);
        repeat (17) @(posedge core_clk);
        rd(tpfu_pkg::TPFU_ADDR_FLAGS, 8'h40, 8'h40);
        wr(tpfu_pkg::TPFU_ADDR_ACC_CTL, 8'h03);
        rd(tpfu_pkg::TPFU_ADDR_ACC_CTL, 8'h03, 8'hFF);
        wr(tpfu_pkg::TPFU_ADDR_FLAGS, 8'h40);
        repeat (129) @(posedge core_clk);
        rd(tpfu_pkg::TPFU_ADDR_FLAGS, 8'h40, 8'h40);
        // Longest rate: quiet for most of an interval after a tick, then set again
        wr(tpfu_pkg::TPFU_ADDR_FLAGS, 8'h40);
        poll_flag(8'h40);
        wr(tpfu_pkg::TPFU_ADDR_FLAGS, 8'h40);
        repeat (100) @(posedge core_clk);
        rd(tpfu_pkg::TPFU_ADDR_FLAGS, 8'h00, 8'h40);
        repeat (30) @(posedge core_clk);
        rd(tpfu_pkg::TPFU_ADDR_FLAGS, 8'h40, 8'h40);
        wr(tpfu_pkg::TPFU_ADDR_ENABLES, 8'h40);
        repeat (2) @(posedge core_clk);
        #1 cmp("irq", 16'h0001, {15'h0000, irq});
        // Counter wrap at divide by one
        wr(tpfu_pkg::TPFU_ADDR_ENABLES, 8'h00);
        rd(tpfu_pkg::TPFU_ADDR_FLAGS, 8'h00, 8'h80);
        for (int n = 0; n < 70000 && free_running_count !== 16'hFF00; n++)
            @(posedge core_clk) #1;
        // Count steps once a cycle, so the bytes read are known
        rd(tpfu_pkg::TPFU_ADDR_CNT_HI, 8'hFF, 8'hFF);
        rd(tpfu_pkg::TPFU_ADDR_CNT_LO, 8'h03, 8'hFF);
        rd(tpfu_pkg::TPFU_ADDR_FLAGS, 8'h00, 8'h80);
        for (int n = 0; n < 300 && free_running_count !== 16'hFFFF; n++)
            @(posedge core_clk) #1;
        rd(tpfu_pkg::TPFU_ADDR_FLAGS, 8'h80, 8'h80);
        print_verdict();
    end
endmodule
